// file: hw/atc_defines.svh
// register map, field positions, reset values and counts of the test block
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH
`define ATC_ADDR_CTRL 7'h01
`define ATC_ADDR_TEST 7'h05
`define ATC_ADDR_SYNC 7'h06
`define ATC_ADDR_CHSEL 7'h0F
`define ATC_ADDR_PERCH 7'h10
`define ATC_CTRL_TEN_BIT 12
`define ATC_TEST_KIND_BIT 0
`define ATC_TEST_PER_LSB 1
`define ATC_TEST_RST 3'h0
`define ATC_SYNC_RST 4'h0
`define ATC_CHSEL_RST 3'h0
`define ATC_PAT_W 11
`define ATC_FLASH_P11 5'h0B
`define ATC_FLASH_P12 5'h0C
`define ATC_FLASH_P16 5'h10
`define ATC_HDR_LAST 5'h07
`define ATC_FRAME_LAST 5'h17
`define ATC_FRAME_DONE 5'h18
`define ATC_NUM_CORES 4
`define ATC_PERCH_REGS 4
`endif

// file: hw/atc_pattern_gen.sv
// ramp and flashing pattern generator with start-up delay after sync
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module atc_pattern_gen #(
    parameter int PAT_W = `ATC_PAT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic syncLevel,
    input wire logic flashMode,
    input wire logic [1:0] periodSel,
    input wire logic [3:0] syncDelay,
    output logic [PAT_W-1:0] patWord
);
    if (PAT_W < 2 || PAT_W > 16) begin : g_chk
        $error("atc_pattern_gen: PAT_W out of range");
    end
    typedef struct packed {
        atc_pkg::atc_state_e st;
        logic [3:0] dly;
        logic [PAT_W-1:0] ramp;
        logic [4:0] phase;
        logic [PAT_W-1:0] word;
    } atc_pg_s;
    atc_pg_s s;
    atc_pg_s next_s;
    logic [4:0] period;

    always_comb begin
        case (periodSel)
            atc_pkg::FLASH_12: period = `ATC_FLASH_P12;
            atc_pkg::FLASH_16: period = `ATC_FLASH_P16;
            default: period = `ATC_FLASH_P11;
        endcase
    end

    always_comb begin
        next_s = s;
        if (clkEn) begin
            if (syncLevel) begin
                // word left untouched so outputs hold during reset
                next_s.st = atc_pkg::ST_HOLD;
            end else begin
                case (s.st)
                    atc_pkg::ST_HOLD: begin
                        next_s.ramp = '0;
                        next_s.phase = 5'h00;
                        next_s.dly = syncDelay;
                        if (syncDelay == 4'h0) begin
                            next_s.st = atc_pkg::ST_RUN;
                        end else begin
                            next_s.st = atc_pkg::ST_DELAY;
                        end
                    end
                    atc_pkg::ST_DELAY: begin
                        next_s.dly = s.dly - 4'h1;
                        if (s.dly == 4'h1) begin
                            next_s.st = atc_pkg::ST_RUN;
                        end
                    end
                    atc_pkg::ST_RUN: begin
                        if (!flashMode) begin
                            next_s.word = s.ramp;
                            next_s.ramp = s.ramp + PAT_W'(1);
                        end else begin
                            next_s.word = (s.phase == 5'h00) ? '1 : '0;
                            if (s.phase == period - 5'h01) begin
                                next_s.phase = 5'h00;
                            end else begin
                                next_s.phase = s.phase + 5'h01;
                            end
                        end
                    end
                    default: next_s.st = atc_pkg::ST_HOLD;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '{atc_pkg::ST_RUN, 4'h0, '0, 5'h00, '0};
        end else begin
            s <= next_s;
        end
    end
    assign patWord = s.word;

    ramp_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && !syncLevel && s.st == atc_pkg::ST_RUN && !flashMode
        |=> s.ramp == $past(s.ramp) + PAT_W'(1) && s.word == $past(s.ramp))
        else $error("ramp did not advance by one");
    flash_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && !syncLevel && s.st == atc_pkg::ST_RUN && flashMode
        && s.phase == 5'h00 |=> s.word == {PAT_W{1'b1}})
        else $error("flash word not all ones");
    flash_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && !syncLevel && s.st == atc_pkg::ST_RUN && flashMode
        && periodSel == 2'h2 && s.phase == 5'h0F |=> s.phase == 5'h00)
        else $error("flash period 16 wrong");
    hold_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        syncLevel |=> $stable(s.word))
        else $error("pattern changed during reset");
    delay_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && !syncLevel && s.st == atc_pkg::ST_DELAY
        |=> (s.st == atc_pkg::ST_DELAY && s.dly == $past(s.dly) - 4'h1)
        || (s.st == atc_pkg::ST_RUN && $past(s.dly) == 4'h1))
        else $error("start-up delay miscounted");
    ramp_wrap_c: cover property (@(posedge core_clk) disable iff (sys_rst)
        s.st == atc_pkg::ST_RUN && !flashMode && s.ramp == '1 ##1 s.ramp == '0);
    delay_max_c: cover property (@(posedge core_clk) disable iff (sys_rst)
        s.st == atc_pkg::ST_DELAY && s.dly == 4'hF);
endmodule
`default_nettype wire

// file: hw/atc_pkg.sv
// types shared by the test-pattern block
`default_nettype none
package atc_pkg;
    typedef enum logic [1:0] {
        FLASH_11 = 2'h0,
        FLASH_12 = 2'h1,
        FLASH_16 = 2'h2,
        FLASH_RSV = 2'h3
    } atc_flash_e;
    // gray order along hold -> delay -> run
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_DELAY = 2'h1,
        ST_RUN = 2'h3
    } atc_state_e;
    typedef enum logic [2:0] {
        CH_NONE = 3'h0,
        CH_A = 3'h1,
        CH_B = 3'h2,
        CH_C = 3'h3,
        CH_D = 3'h4
    } atc_chan_e;
endpackage
`default_nettype wire

// file: hw/atc_serial_port.sv
// serial frame shifter: 1 read bit, 7 address bits, 16 data bits, msb first
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module atc_serial_port (
    input wire logic serialClk,
    input wire logic sys_rst,
    input wire logic serialCsN,
    input wire logic serialMosi,
    input wire logic [15:0] rdData,
    output logic [6:0] peekAddr,
    output logic wrStb,
    output logic [6:0] wrAddr,
    output logic [15:0] wrData,
    output logic serialMiso,
    output logic serialMisoOe
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [15:0] shift;
        logic isRead;
        logic [6:0] addr;
        logic [15:0] tx;
        logic oe;
    } atc_sp_s;
    atc_sp_s s;
    atc_sp_s next_s;
    logic [15:0] sh;
    // the serial clock stops between frames, so the frame ends by chip select
    logic frameRst;
    assign frameRst = sys_rst | serialCsN;

    always_comb begin
        next_s = s;
        wrStb = 1'b0;
        sh = {s.shift[14:0], serialMosi};
        if (s.cnt != `ATC_FRAME_DONE) begin
            next_s.cnt = s.cnt + 5'h01;
            next_s.shift = sh;
        end
        if (s.cnt == `ATC_HDR_LAST) begin
            next_s.isRead = sh[7];
            next_s.addr = sh[6:0];
            next_s.tx = rdData;
            next_s.oe = sh[7];
        end else if (s.oe) begin
            next_s.tx = {s.tx[14:0], 1'b0};
        end
        if (s.cnt == `ATC_FRAME_LAST && !s.isRead) begin
            wrStb = 1'b1;
        end
    end

    always_ff @(posedge serialClk or posedge frameRst) begin
        if (frameRst) begin
            s <= '{5'h00, 16'h0000, 1'b0, 7'h00, 16'h0000, 1'b0};
        end else begin
            s <= next_s;
        end
    end
    assign peekAddr = sh[6:0];
    assign wrAddr = s.addr;
    assign wrData = sh;
    assign serialMiso = s.tx[15];
    assign serialMisoOe = s.oe;
endmodule
`default_nettype wire

// file: hw/atc_top.sv
// test pattern, start-up delay and channel selector registers of a quad adc
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module atc_top #(
    parameter int NUM_CORES = `ATC_NUM_CORES,
    parameter int PAT_W = `ATC_PAT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic serialClk,
    input wire logic serialCsN,
    input wire logic serialMosi,
    output logic serialMiso,
    output logic serialMisoOe,
    input wire logic syncPulsePos,
    input wire logic syncPulseNeg,
    input wire logic [NUM_CORES*PAT_W-1:0] dataIn,
    output logic [NUM_CORES*PAT_W-1:0] dataOut
);
    if (NUM_CORES != `ATC_NUM_CORES || PAT_W != `ATC_PAT_W) begin : g_chk
        $error("atc_top: channel selector serves four 11-bit cores only");
    end

    // ************************************************************
    // serial-clock side: register file
    // ************************************************************
    // per-channel copies sit beside the common fields so that one process
    // owns all of them; nothing here moves except on a write strobe
    typedef struct packed {
        logic testEn;
        logic [2:0] test;
        logic [3:0] syncDly;
        logic [2:0] chSel;
        logic [`ATC_NUM_CORES-1:0][`ATC_PERCH_REGS-1:0][15:0] perCh;
    } atc_link_s;
    atc_link_s ls;
    atc_link_s next_ls;

    logic [6:0] peekAddr;
    logic wrStb;
    logic [6:0] wrAddr;
    logic [15:0] wrData;
    logic [15:0] rdData;

    atc_serial_port u_port (
        .serialClk(serialClk),
        .sys_rst(sys_rst),
        .serialCsN(serialCsN),
        .serialMosi(serialMosi),
        .rdData(rdData),
        .peekAddr(peekAddr),
        .wrStb(wrStb),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .serialMiso(serialMiso),
        .serialMisoOe(serialMisoOe)
    );

    // channel decode shared by read and write paths
    function automatic logic chanValid(input logic [2:0] sel);
        chanValid = sel >= atc_pkg::CH_A && sel <= atc_pkg::CH_D;
    endfunction
    function automatic logic perChAddr(input logic [6:0] a);
        perChAddr = a >= `ATC_ADDR_PERCH
            && a < `ATC_ADDR_PERCH + 7'(`ATC_PERCH_REGS);
    endfunction

    logic [1:0] rdCore;
    logic [1:0] wrCore;
    assign rdCore = 2'(ls.chSel - 3'h1);
    assign wrCore = 2'(ls.chSel - 3'h1);

    // read data is chosen from the address as it completes, eight edges in,
    // so the shifter can load the word at that same edge
    always_comb begin
        rdData = 16'h0000;
        case (peekAddr)
            `ATC_ADDR_CTRL: rdData[`ATC_CTRL_TEN_BIT] = ls.testEn;
            `ATC_ADDR_TEST: rdData[2:0] = ls.test;
            `ATC_ADDR_SYNC: rdData[3:0] = ls.syncDly;
            `ATC_ADDR_CHSEL: rdData[2:0] = ls.chSel;
            default: begin
                if (perChAddr(peekAddr) && chanValid(ls.chSel)) begin
                    rdData = ls.perCh[rdCore][peekAddr[1:0]];
                end
            end
        endcase
    end

    always_comb begin
        next_ls = ls;
        if (wrStb) begin
            case (wrAddr)
                `ATC_ADDR_CTRL: next_ls.testEn = wrData[`ATC_CTRL_TEN_BIT];
                `ATC_ADDR_TEST: next_ls.test = wrData[2:0];
                `ATC_ADDR_SYNC: next_ls.syncDly = wrData[3:0];
                `ATC_ADDR_CHSEL: next_ls.chSel = wrData[2:0];
                default: begin
                    // no channel selected: the write is dropped
                    if (perChAddr(wrAddr) && chanValid(ls.chSel)) begin
                        next_ls.perCh[wrCore][wrAddr[1:0]] = wrData;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge serialClk or posedge sys_rst) begin
        if (sys_rst) begin
            ls.testEn <= 1'b0;
            ls.test <= `ATC_TEST_RST;
            ls.syncDly <= `ATC_SYNC_RST;
            ls.chSel <= `ATC_CHSEL_RST;
            ls.perCh <= '0;
        end else begin
            ls <= next_ls;
        end
    end

    // ************************************************************
    // converter-clock side: crossing and output words
    // ************************************************************
    // config fields are quasi-static levels; a multi-bit change may be seen
    // split for one cycle, which is harmless for a test pattern
    typedef struct packed {
        logic tenM;
        logic tenS;
        logic kindM;
        logic kindS;
        logic [1:0] perM;
        logic [1:0] perS;
        logic [3:0] dlyM;
        logic [3:0] dlyS;
        logic spM;
        logic spS;
        logic snM;
        logic snS;
        logic [`ATC_NUM_CORES-1:0][`ATC_PAT_W-1:0] out;
    } atc_core_s;
    atc_core_s cs;
    atc_core_s next_cs;

    logic syncLevel;
    logic [PAT_W-1:0] patWord;
    assign syncLevel = cs.spS & ~cs.snS;

    // one generator feeds every core: the cores leave sync together, which
    // is what keeps the test words identical across the channels
    atc_pattern_gen #(
        .PAT_W(PAT_W)
    ) u_gen (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .syncLevel(syncLevel),
        .flashMode(cs.kindS),
        .periodSel(cs.perS),
        .syncDelay(cs.dlyS),
        .patWord(patWord)
    );

    // test enable steers the mux, not the generator, so a pattern that is
    // switched on is already in step; the cost is a generator always running
    always_comb begin
        next_cs = cs;
        if (clkEn) begin
            next_cs.tenM = ls.testEn;
            next_cs.tenS = cs.tenM;
            next_cs.kindM = ls.test[`ATC_TEST_KIND_BIT];
            next_cs.kindS = cs.kindM;
            next_cs.perM = ls.test[`ATC_TEST_PER_LSB +: 2];
            next_cs.perS = cs.perM;
            next_cs.dlyM = ls.syncDly;
            next_cs.dlyS = cs.dlyM;
            next_cs.spM = syncPulsePos;
            next_cs.spS = cs.spM;
            next_cs.snM = syncPulseNeg;
            next_cs.snS = cs.snM;
            for (int i = 0; i < `ATC_NUM_CORES; i++) begin
                // every core carries the same 11-bit test word at once
                if (cs.tenS) begin
                    next_cs.out[i] = patWord;
                end else begin
                    next_cs.out[i] = dataIn[i*PAT_W +: PAT_W];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs <= '0;
        end else begin
            cs <= next_cs;
        end
    end
    assign dataOut = cs.out;

    // ************************************************************
    // checks
    // ************************************************************
    test_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && !cs.tenS |=> dataOut == $past(dataIn))
        else $error("data passed wrong while test off");
    all_cores_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && cs.tenS |=> cs.out[0] == $past(patWord)
        && cs.out[3] == $past(patWord) && cs.out[1] == cs.out[2])
        else $error("cores not carrying the same pattern");
    route_b_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        wrStb && wrAddr == `ATC_ADDR_PERCH && ls.chSel == 3'h2
        |=> ls.perCh[1][0] == $past(wrData))
        else $error("write to core B copy missing");
    drop_write_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        wrStb && !chanValid(ls.chSel) |=> $stable(ls.perCh))
        else $error("per-channel write with no channel");
    read_zero_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        perChAddr(peekAddr) && (ls.chSel == 3'h0 || ls.chSel > 3'h4)
        |-> rdData == 16'h0000)
        else $error("per-channel read without channel not zero");
    // each core's copy of the first per-channel word, one check per code
    route_a_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        wrStb && wrAddr == `ATC_ADDR_PERCH && ls.chSel == 3'h1
        |=> ls.perCh[0][0] == $past(wrData))
        else $error("write to core A copy missing");
    route_c_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        wrStb && wrAddr == `ATC_ADDR_PERCH && ls.chSel == 3'h3
        |=> ls.perCh[2][0] == $past(wrData))
        else $error("write to core C copy missing");
    route_d_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        wrStb && wrAddr == `ATC_ADDR_PERCH && ls.chSel == 3'h4
        |=> ls.perCh[3][0] == $past(wrData))
        else $error("write to core D copy missing");
    read_a_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        perChAddr(peekAddr) && ls.chSel == 3'h1
        |-> rdData == ls.perCh[0][peekAddr[1:0]])
        else $error("read did not reach core A copy");
    read_d_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        perChAddr(peekAddr) && ls.chSel == 3'h4
        |-> rdData == ls.perCh[3][peekAddr[1:0]])
        else $error("read did not reach core D copy");
    ctrl_read_a: assert property (@(posedge serialClk) disable iff (sys_rst)
        peekAddr == `ATC_ADDR_CTRL |-> rdData == {3'h0, ls.testEn, 12'h000})
        else $error("control read shows more than test enable");
    read_b_c: cover property (@(posedge serialClk) disable iff (sys_rst)
        perChAddr(peekAddr) && ls.chSel == 3'h2);
    flash_on_c: cover property (@(posedge core_clk) disable iff (sys_rst)
        cs.tenS && cs.kindS && cs.perS == 2'h2 && patWord == '1);
    chan_d_c: cover property (@(posedge serialClk) disable iff (sys_rst)
        wrStb && ls.chSel == 3'h4 && perChAddr(wrAddr));
endmodule
`default_nettype wire

// file: testbench/atc_host_model.sv
// serial host model that frames register reads and writes
`timescale 1ns/1ns
`default_nettype none
module atc_host_model (
    output logic serialClk,
    output logic serialCsN,
    output logic serialMosi,
    input wire logic serialMiso,
    input wire logic serialMisoOe
);
    // ****************************************
    // frame engine
    // ****************************************
    localparam int HALF = 32;
    initial begin
        serialClk = 1'b0;
        serialCsN = 1'b1;
        serialMosi = 1'b0;
    end
    // clock stands still between frames; mosi toggles when it carries
    // nothing so a stale level is never mistaken for data
    task automatic frame(input logic isRead, input logic [6:0] addr,
                         input logic [15:0] wData, output logic [15:0] rData);
        logic [23:0] bits;
        begin
            bits = {isRead, addr, wData};
            rData = 16'h0000;
            serialCsN = 1'b0;
            for (int i = 23; i >= 0; i--) begin
                serialMosi = (isRead && i < 16) ? ~serialMosi : bits[i];
                #HALF;
                if (i < 16) begin
                    // a bit only counts while the block owns the line
                    rData = {rData[14:0], serialMiso & serialMisoOe};
                end
                serialClk = 1'b1;
                #HALF;
                serialClk = 1'b0;
            end
            #HALF;
            serialCsN = 1'b1;
            serialMosi = ~serialMosi;
            #(2 * HALF);
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/test_adc_test_sync_chan_select.sv
// self-checking bench for the test pattern and channel selector block
`timescale 1ns/1ns
`default_nettype none
`include "atc_defines.svh"
module test_adc_test_sync_chan_select;
    logic core_clk, sys_rst, clkEn, syncPulsePos, syncPulseNeg;
    logic serialClk, serialCsN, serialMosi, serialMiso, serialMisoOe;
    logic [43:0] dataIn, dataOut;
    logic [15:0] rd, chVal[4];
    logic [31:0] rnd;
    logic [10:0] expW;
    int failures, num_checks, cycles, seed, lat0, lat15, per, lat;
    int periods[4] = '{11, 12, 16, 11};
    atc_top atc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .clkEn(clkEn), .serialClk(serialClk), .serialCsN(serialCsN),
        .serialMosi(serialMosi), .serialMiso(serialMiso),
        .serialMisoOe(serialMisoOe), .syncPulsePos(syncPulsePos),
        .syncPulseNeg(syncPulseNeg), .dataIn(dataIn), .dataOut(dataOut));
    atc_host_model atc_host_model_inst (.serialClk(serialClk),
        .serialCsN(serialCsN), .serialMosi(serialMosi),
        .serialMiso(serialMiso), .serialMisoOe(serialMisoOe));
    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("unexpected at %0t: run timed out", $time);
            results();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [43:0] got, input logic [43:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // the wait lets the new setting cross into the converter domain
    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        atc_host_model_inst.frame(1'b0, addr, data, rd);
        repeat (8) @(negedge core_clk);
    endtask
    task automatic rdChk(input logic [6:0] addr, input logic [15:0] exp);
        atc_host_model_inst.frame(1'b1, addr, 16'h0000, rd);
        check({28'h0, rd}, {28'h0, exp});
    endtask
    task automatic passThru();
        for (int k = 0; k < 20; k++) begin
            rnd = $random(seed);
            dataIn = {rnd[11:0], rnd};
            @(negedge core_clk);
            check(dataOut, dataIn);
        end
    endtask
    // hold under sync, then find the first two words after start-up;
    // matching a pair keeps a held word equal to the first from fooling it
    task automatic syncRun(input logic [10:0] w0, input logic [10:0] w1,
                           output int latency);
        logic [43:0] held;
        logic [10:0] prev;
        begin
            syncPulsePos = 1'b1;
            syncPulseNeg = 1'b0;
            repeat (6) @(negedge core_clk);
            held = dataOut;
            repeat (8) begin
                @(negedge core_clk);
                check(dataOut, held);
            end
            syncPulsePos = 1'b0;
            syncPulseNeg = 1'b1;
            latency = 0;
            prev = dataOut[10:0];
            @(negedge core_clk);
            while (!(prev === w0 && dataOut[10:0] === w1) && latency < 100) begin
                prev = dataOut[10:0];
                @(negedge core_clk);
                latency++;
            end
            check({33'h0, dataOut[10:0]}, {33'h0, w1});
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 32'h8AF87980;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        syncPulsePos = 1'b0;
        syncPulseNeg = 1'b1;
        dataIn = 44'h0;
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        passThru();
        rdChk(`ATC_ADDR_CTRL, 16'h0000);
        rdChk(`ATC_ADDR_TEST, 16'h0000);
        rdChk(`ATC_ADDR_SYNC, 16'h0000);
        rdChk(`ATC_ADDR_CHSEL, 16'h0000);
        wr(`ATC_ADDR_PERCH, 16'h1234);
        rdChk(`ATC_ADDR_PERCH, 16'h0000);
        wr(7'h07, 16'hFFFF);
        rdChk(7'h07, 16'h0000);
        wr(`ATC_ADDR_TEST, 16'hFFFF);
        rdChk(`ATC_ADDR_TEST, 16'h0007);
        wr(`ATC_ADDR_SYNC, 16'hFFFF);
        rdChk(`ATC_ADDR_SYNC, 16'h000F);
        wr(`ATC_ADDR_CTRL, 16'hFFFF);
        rdChk(`ATC_ADDR_CTRL, 16'h1000);
        // channel field is set before every per-channel access
        for (int c = 0; c < 4; c++) begin
            rnd = $random(seed);
            chVal[c] = rnd[15:0];
            wr(`ATC_ADDR_CHSEL, 16'(c + 1));
            wr(`ATC_ADDR_PERCH, chVal[c]);
        end
        // one address for all cores, so only the selector tells them apart
        for (int c = 0; c < 4; c++) begin
            wr(`ATC_ADDR_CHSEL, 16'(c + 1));
            rdChk(`ATC_ADDR_PERCH, chVal[c]);
        end
        for (int c = 5; c < 8; c++) begin
            wr(`ATC_ADDR_CHSEL, 16'(c));
            wr(`ATC_ADDR_PERCH, 16'hBEEF);
            rdChk(`ATC_ADDR_PERCH, 16'h0000);
        end
        wr(`ATC_ADDR_CHSEL, 16'h0001);
        rdChk(`ATC_ADDR_PERCH, chVal[0]);
        wr(`ATC_ADDR_SYNC, 16'h0000);
        wr(`ATC_ADDR_TEST, 16'h0000);
        syncRun(11'h000, 11'h001, lat0);
        expW = 11'h001;
        // long enough that the ramp wraps even with the enable gaps
        for (int k = 0; k < 2500; k++) begin
            rnd = $random(seed);
            clkEn = (rnd[2:0] != 3'h0);
            @(negedge core_clk);
            if (clkEn) begin
                expW = expW + 11'h001;
            end
            check(dataOut, {4{expW}});
        end
        clkEn = 1'b1;
        wr(`ATC_ADDR_SYNC, 16'h000F);
        syncRun(11'h000, 11'h001, lat15);
        check(44'(lat15 - lat0), 44'h00F);
        wr(`ATC_ADDR_SYNC, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            per = periods[c];
            wr(`ATC_ADDR_TEST, {13'h0, 2'(c), 1'b1});
            syncRun(11'h7FF, 11'h000, lat);
            for (int k = 2; k <= 3 * per + 1; k++) begin
                @(negedge core_clk);
                expW = (k % per == 0) ? 11'h7FF : 11'h000;
                check(dataOut, {4{expW}});
            end
        end
        wr(`ATC_ADDR_CTRL, 16'h0000);
        passThru();
        results();
    end
endmodule
`default_nettype wire
